/* hw/seq_fifo_regs.sv */
/*
 Sequencer and shared-SRAM control registers behind an AXI4-Lite slave.
 Assumes a sequencer engine that reports sequence end and a data queue that
 reports its word count, both on the same clock.
*/
// The AXI4-Lite register port was chosen for this implementation.
`default_nettype none
`include "seqregs_consts.svh"
module seq_fifo_regs (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sequenceEnd,
   input wire logic [10:0] wordsHeld,
   output logic [3:0] startSequence,
   output seqregs_pkg::seq_desc_t [3:0] seqDesc,
   output logic [10:0] commandWritePointer,
   output seqregs_pkg::mem_part_t memPart,
   output logic [10:0] upperWatermark,
   output logic [7:0] gpioSync,
   output logic sleepRequest
);
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   logic [15:0] awAddr;
   logic awHeld;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic wHeld;
   logic doWrite;
   logic [31:0] maskedData;
   logic writeHit;
   logic [31:0] readValue;
   logic readHit;
   logic [15:0] triggerReq;
   logic sleepTriggerBit;
   logic [19:0] lockValue;
   logic unlocked;
   logic [31:0] descWord [4];
   logic [3:0] descWrite;
   seqregs_pkg::seq_state_t seqState;

   // merge new bytes into old word by strobes
   function automatic logic [31:0] mergeBytes(input logic [31:0] oldWord, input logic [31:0] newWord,
                                               input logic [3:0] strb);
      logic [31:0] result;
      result = oldWord;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            result[i*8 +: 8] = newWord[i*8 +: 8];
      end
      return result;
   endfunction

   // true when an offset names a register of this bank
   function automatic logic isMapped(input logic [15:0] addr);
      unique case (addr)
         `OFS_TRIG_REQ, `OFS_SYNC_OUT, `OFS_SLEEP_LOCK, `OFS_SLEEP_TRIG, `OFS_SEQ0_DESC,
         `OFS_SEQ1_DESC, `OFS_SEQ2_DESC, `OFS_SEQ3_DESC, `OFS_CMD_WPTR, `OFS_MEM_PART,
         `OFS_DQ_THRES, `OFS_DQ_COUNT, `OFS_SEQ_STATUS:
            return 1'b1;
         default:
            return 1'b0;
      endcase
   endfunction

   // write channels taken independently, held until the response is accepted
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready = !wHeld && !s_axi_bvalid;
   assign doWrite = awHeld && wHeld && !s_axi_bvalid;

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         awHeld <= 1'b0;
         awAddr <= 16'h0000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         awHeld <= 1'b1;
         awAddr <= {s_axi_awaddr[15:2], 2'b00};
      end
      else if (doWrite)
         awHeld <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         wHeld <= 1'b0;
         wData <= 32'h00000000;
         wStrb <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         wHeld <= 1'b1;
         wData <= s_axi_wdata;
         wStrb <= s_axi_wstrb;
      end
      else if (doWrite)
         wHeld <= 1'b0;
   end

   // response one cycle after both halves are in
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (doWrite)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   assign writeHit = doWrite && isMapped(awAddr);
   // unwritten bytes keep current contents
   assign maskedData = mergeBytes(readValue, wData, wStrb);

   // descriptor and lock helpers
   assign descWrite[0] = writeHit && awAddr == `OFS_SEQ0_DESC;
   assign descWrite[1] = writeHit && awAddr == `OFS_SEQ1_DESC;
   assign descWrite[2] = writeHit && awAddr == `OFS_SEQ2_DESC;
   assign descWrite[3] = writeHit && awAddr == `OFS_SEQ3_DESC;

   for (genvar g = 0; g < 4; g++)
   begin : gDesc
      seq_desc_reg descReg (
         .clock(clock),
         .nrst(nrst),
         .writeEn(descWrite[g]),
         .writeData(maskedData),
         .desc(seqDesc[g]),
         .readWord(descWord[g])
      );
   end

   sleep_lock_ctrl lockCtrl (
      .clock(clock),
      .nrst(nrst),
      .lockWrite(writeHit && awAddr == `OFS_SLEEP_LOCK),
      .lockData(maskedData[`LOCK_HI:0]),
      .lockValue(lockValue),
      .unlocked(unlocked)
   );

   // plain control registers, reserved bits dropped
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         commandWritePointer <= 11'h000;
         memPart <= `MEM_PART_RESET;
         upperWatermark <= 11'h000;
         gpioSync <= 8'h00;
      end
      else if (writeHit)
      begin
         unique case (awAddr)
            `OFS_CMD_WPTR:
               commandWritePointer <= maskedData[`PTR_HI:`PTR_LO];
            `OFS_MEM_PART:
            begin
               memPart.dataMemoryMode <= maskedData[`DMODE_HI:`DMODE_LO];
               memPart.dataMemorySize <= maskedData[`DSIZE_HI:`DSIZE_LO];
               memPart.commandMemoryMode <= maskedData[`CMODE_HI:`CMODE_LO];
               memPart.commandMemorySize <= maskedData[`CSIZE_HI:`CSIZE_LO];
            end
            `OFS_DQ_THRES:
               upperWatermark <= maskedData[`CNT_HI:`CNT_LO];
            `OFS_SYNC_OUT:
               gpioSync <= maskedData[7:0];
            default:
               ;
         endcase
      end
   end

   // trigger bits self-clear once the start pulse is issued
   always_ff @(posedge clock)
   begin
      if (!nrst)
         triggerReq <= 16'h0000;
      else if (writeHit && awAddr == `OFS_TRIG_REQ)
         triggerReq <= {12'h000, maskedData[3:0]};
      else
         triggerReq <= 16'h0000;
   end
   assign startSequence = triggerReq[3:0];

   // sleep bit only accepted while unlocked; cleared once the sleep state is entered
   always_ff @(posedge clock)
   begin
      if (!nrst)
         sleepTriggerBit <= 1'b0;
      else if (writeHit && awAddr == `OFS_SLEEP_TRIG && unlocked)
         sleepTriggerBit <= maskedData[0];
      else if (seqState == seqregs_pkg::SEQ_SLEEP)
         sleepTriggerBit <= 1'b0;
   end

   // tracks sequence run and sleep entry at its end
   always_ff @(posedge clock)
   begin
      if (!nrst)
         seqState <= seqregs_pkg::SEQ_IDLE;
      else
      begin
         unique case (seqState)
            seqregs_pkg::SEQ_IDLE:
               if (|startSequence)
                  seqState <= seqregs_pkg::SEQ_RUN;
            seqregs_pkg::SEQ_RUN:
               if (sequenceEnd)
                  seqState <= sleepTriggerBit ? seqregs_pkg::SEQ_SLEEP : seqregs_pkg::SEQ_IDLE;
            seqregs_pkg::SEQ_SLEEP:
               if (|startSequence)
                  seqState <= seqregs_pkg::SEQ_RUN; // wake by next trigger
            default:
               seqState <= seqregs_pkg::SEQ_IDLE;
         endcase
      end
   end
   assign sleepRequest = (seqState == seqregs_pkg::SEQ_SLEEP);

   // read mux, reserved bits zero
   always_comb
   begin
      readValue = 32'h00000000;
      unique case (s_axi_bvalid || awHeld ? awAddr : {s_axi_araddr[15:2], 2'b00})
         `OFS_TRIG_REQ: readValue = {16'h0000, triggerReq};
         `OFS_SYNC_OUT: readValue = {24'h000000, gpioSync};
         `OFS_SLEEP_LOCK: readValue = {12'h000, lockValue};
         `OFS_SLEEP_TRIG: readValue = {31'h00000000, sleepTriggerBit};
         `OFS_SEQ0_DESC: readValue = descWord[0];
         `OFS_SEQ1_DESC: readValue = descWord[1];
         `OFS_SEQ2_DESC: readValue = descWord[2];
         `OFS_SEQ3_DESC: readValue = descWord[3];
         `OFS_CMD_WPTR: readValue = {21'h000000, commandWritePointer};
         `OFS_MEM_PART: readValue = {20'h00000, memPart};
         `OFS_DQ_THRES: readValue = {5'h00, upperWatermark, 16'h0000};
         `OFS_DQ_COUNT: readValue = {5'h00, wordsHeld, 16'h0000};
         `OFS_SEQ_STATUS: readValue = {29'h00000000, seqState};
         default: readValue = 32'h00000000;
      endcase
   end

   // reads wait while a write is pending so the shared mux is free
   assign s_axi_arready = !s_axi_rvalid && !awHeld && !s_axi_bvalid;

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= readValue;
         s_axi_rresp <= isMapped({s_axi_araddr[15:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   a_lock_gates_sleep: assert property (@(posedge clock) disable iff (!nrst)
      (!unlocked && !sleepTriggerBit) |=> !sleepTriggerBit)
      else $error("sleep bit set while locked");
   a_sleep_at_end: assert property (@(posedge clock) disable iff (!nrst)
      (seqState == seqregs_pkg::SEQ_RUN && sequenceEnd && sleepTriggerBit) |=> sleepRequest)
      else $error("no sleep after sequence end");
   a_no_early_sleep: assert property (@(posedge clock) disable iff (!nrst)
      (seqState == seqregs_pkg::SEQ_RUN && !sequenceEnd) |=> !sleepRequest)
      else $error("sleep before sequence end");
   a_trigger_pulse: assert property (@(posedge clock) disable iff (!nrst)
      (writeHit && awAddr == `OFS_TRIG_REQ) |=> startSequence == $past(maskedData[3:0]) ##1 startSequence == 4'h0)
      else $error("trigger pulse wrong");
   a_trig_reserved: assert property (@(posedge clock) disable iff (!nrst)
      triggerReq[15:4] == 12'h000)
      else $error("trigger reserved bits set");
   a_count_read: assert property (@(posedge clock) disable iff (!nrst)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_DQ_COUNT) |=> s_axi_rdata == {5'h00, $past(wordsHeld), 16'h0000})
      else $error("count read wrong");
   a_gpio_follows: assert property (@(posedge clock) disable iff (!nrst)
      (writeHit && awAddr == `OFS_SYNC_OUT) |=> gpioSync == $past(maskedData[7:0]))
      else $error("gpio not updated");
   a_wptr_write: assert property (@(posedge clock) disable iff (!nrst)
      (writeHit && awAddr == `OFS_CMD_WPTR) |=> commandWritePointer == $past(maskedData[10:0]))
      else $error("write pointer not updated");
   a_mem_part: assert property (@(posedge clock) disable iff (!nrst)
      (writeHit && awAddr == `OFS_MEM_PART) |=> memPart == $past(maskedData[11:0]))
      else $error("partition not updated");
   a_thres_write: assert property (@(posedge clock) disable iff (!nrst)
      (writeHit && awAddr == `OFS_DQ_THRES) |=> upperWatermark == $past(maskedData[26:16]))
      else $error("threshold not updated");
   a_desc_write: assert property (@(posedge clock) disable iff (!nrst)
      descWrite[2] |=> seqDesc[2] == {$past(maskedData[26:16]), $past(maskedData[10:0])})
      else $error("descriptor not updated");
   a_lock_pw: assert property (@(posedge clock) disable iff (!nrst)
      (writeHit && awAddr == `OFS_SLEEP_LOCK) |=> unlocked == ($past(maskedData[19:0]) == `SLEEP_PASSWORD))
      else $error("lock state wrong");
   a_reserved_zero: assert property (@(posedge clock) disable iff (!nrst)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_MEM_PART) |=> s_axi_rdata[31:12] == 20'h00000)
      else $error("reserved bits nonzero");
   a_mode_reset: assert property (@(posedge clock)
      !nrst |=> memPart.dataMemoryMode == 3'h2)
      else $error("data mode reset wrong");
endmodule // seq_fifo_regs
`default_nettype wire

/* hw/seqregs_consts.svh */
/*
 Offsets, field positions, reset values and the unlock password for the
 sequencer and memory-partition register bank.
 Assumes inclusion by bare name from design files.
*/
`ifndef SEQREGS_CONSTS_SVH
`define SEQREGS_CONSTS_SVH

`define OFS_TRIG_REQ 16'h0430
`define OFS_SYNC_OUT 16'h2054
`define OFS_SLEEP_LOCK 16'h2118
`define OFS_SLEEP_TRIG 16'h211c
`define OFS_SEQ0_DESC 16'h21cc
`define OFS_SEQ2_DESC 16'h21d0
`define OFS_CMD_WPTR 16'h21d4
`define OFS_MEM_PART 16'h21d8
`define OFS_DQ_THRES 16'h21e0
`define OFS_SEQ3_DESC 16'h21e4
`define OFS_SEQ1_DESC 16'h21e8
`define OFS_DQ_COUNT 16'h2200
`define OFS_SEQ_STATUS 16'h2204

`define CNT_HI 26
`define CNT_LO 16
`define PTR_HI 10
`define PTR_LO 0
`define DMODE_HI 11
`define DMODE_LO 9
`define DSIZE_HI 8
`define DSIZE_LO 6
`define CMODE_HI 5
`define CMODE_LO 3
`define CSIZE_HI 2
`define CSIZE_LO 0
`define LOCK_HI 19

`define MEM_PART_RESET 12'h410
`define SLEEP_PASSWORD 20'ha47e5

`endif

/* hw/seqregs_pkg.sv */
/*
 Types shared by the sequencer register bank and its helpers.
 Assumes the consts header is also available to users.
*/
`default_nettype none
package seqregs_pkg;
   // one sequence descriptor: instruction count and start pointer
   typedef struct packed {
      logic [10:0] instrCount;
      logic [10:0] startPointer;
   } seq_desc_t;

   // sram split between command and data memory
   typedef struct packed {
      logic [2:0] dataMemoryMode;
      logic [2:0] dataMemorySize;
      logic [2:0] commandMemoryMode;
      logic [2:0] commandMemorySize;
   } mem_part_t;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_RUN = 3'b010,
      SEQ_SLEEP = 3'b100
   } seq_state_t;
endpackage : seqregs_pkg
`default_nettype wire

/* hw/seq_desc_reg.sv */
/*
 One sequence descriptor register: 11-bit count and 11-bit start pointer.
 Assumes the bus slave delivers a one-cycle write strobe with byte-masked data.
*/
`default_nettype none
`include "seqregs_consts.svh"
module seq_desc_reg (
   input wire logic clock,
   input wire logic nrst,
   input wire logic writeEn,
   input wire logic [31:0] writeData,
   output seqregs_pkg::seq_desc_t desc,
   output logic [31:0] readWord
);
   // reserved bits dropped on write
   always_ff @(posedge clock)
   begin
      if (!nrst)
         desc <= '0;
      else if (writeEn)
      begin
         desc.instrCount <= writeData[`CNT_HI:`CNT_LO];
         desc.startPointer <= writeData[`PTR_HI:`PTR_LO];
      end
   end

   // reserved bits read zero
   assign readWord = {5'h00, desc.instrCount, 5'h00, desc.startPointer};
endmodule // seq_desc_reg
`default_nettype wire

/* hw/sleep_lock_ctrl.sv */
/*
 Password lock guarding the sleep trigger bit.
 Assumes a one-cycle write strobe from the bus slave.
*/
`default_nettype none
`include "seqregs_consts.svh"
module sleep_lock_ctrl (
   input wire logic clock,
   input wire logic nrst,
   input wire logic lockWrite,
   input wire logic [19:0] lockData,
   output logic [19:0] lockValue,
   output logic unlocked
);
   // any value other than the password relocks
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         lockValue <= 20'h00000;
         unlocked <= 1'b0;
      end
      else if (lockWrite)
      begin
         lockValue <= lockData;
         unlocked <= (lockData == `SLEEP_PASSWORD);
      end
   end
endmodule // sleep_lock_ctrl
`default_nettype wire

/* tb/sequencer_fifo_control_regs_test.sv */
/*
 Self-checking bench for the sequencer register bank: AXI4-Lite master tasks,
 queue-based scoreboard, trigger, sleep-lock and unmapped-access scenarios.
 Assumes the design files under hw/ and the consts header on the include path.
*/
`default_nettype none
`include "seqregs_consts.svh"
`define CHK(act, exp) begin numChecks++; if ((act) !== (exp)) begin errors++; \
   $display("mismatch at %0t: got %h expected %h", $time, (act), (exp)); end end
module sequencer_fifo_control_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [15:0] awaddr = 16'h0;
   logic [15:0] araddr = 16'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, sleepRequest;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic sequenceEnd = 1'b0;
   logic [10:0] wordsHeld = 11'h0;
   logic [3:0] startSequence;
   seqregs_pkg::seq_desc_t [3:0] seqDesc;
   logic [10:0] commandWritePointer, upperWatermark;
   seqregs_pkg::mem_part_t memPart;
   logic [7:0] gpioSync;
   logic [33:0] readQ[$];
   logic [1:0] respQ[$];
   logic [3:0] trigQ[$];
   logic [33:0] expRead;
   logic [1:0] expResp;
   logic [3:0] expTrig;
   int errors = 0;
   int numChecks = 0;
   int cycles = 0;
   int seed;
   logic [31:0] wv [7];
   logic [31:0] d;
   logic [10:0] w;
   localparam logic [15:0] OFS [7] = '{`OFS_SEQ0_DESC, `OFS_SEQ2_DESC, `OFS_SEQ3_DESC, `OFS_SEQ1_DESC,
      `OFS_CMD_WPTR, `OFS_DQ_THRES, `OFS_SYNC_OUT};
   localparam logic [31:0] MSK [7] = '{32'h07ff07ff, 32'h07ff07ff, 32'h07ff07ff, 32'h07ff07ff,
      32'h000007ff, 32'h07ff0000, 32'h000000ff};
   localparam int SEQ_IDX [4] = '{0, 2, 3, 1};

   seq_fifo_regs u_dut (.clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sequenceEnd(sequenceEnd),
      .wordsHeld(wordsHeld), .startSequence(startSequence), .seqDesc(seqDesc),
      .commandWritePointer(commandWritePointer), .memPart(memPart), .upperWatermark(upperWatermark),
      .gpioSync(gpioSync), .sleepRequest(sleepRequest));

   always #2 clock = ~clock;

   // hang guard, far above the few hundred cycles the sequence needs
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d errors %0d", numChecks, errors);
      if (errors == 0 && numChecks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // address and data offered together, each released when taken
   task automatic axiWrite(input logic [15:0] a, input logic [31:0] dat, input logic [3:0] s,
                           input logic [1:0] r);
      logic awDone;
      logic wDone;
      awDone = 1'b0;
      wDone = 1'b0;
      respQ.push_back(r);
      if (a == `OFS_TRIG_REQ && s[0] && dat[3:0] != 4'h0)
         trigQ.push_back(dat[3:0]);
      @(posedge clock);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= dat;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(awDone && wDone))
      begin
         @(posedge clock);
         if (!awDone && awready)
         begin
            awvalid <= 1'b0;
            awDone = 1'b1;
         end
         if (!wDone && wready)
         begin
            wvalid <= 1'b0;
            wDone = 1'b1;
         end
      end
      do @(posedge clock); while (!bvalid);
      bready <= 1'b0;
   endtask

   task automatic axiRead(input logic [15:0] a, input logic [33:0] e);
      readQ.push_back(e);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clock); while (!rvalid);
      rready <= 1'b0;
   endtask

   // start sequence 0, issue the sleep write last, then end the sequence
   task automatic runSequence(input logic [31:0] sleepWord);
      axiWrite(`OFS_TRIG_REQ, 32'h1, 4'hf, 2'b00);
      axiWrite(`OFS_SLEEP_TRIG, sleepWord, 4'hf, 2'b00);
      @(posedge clock);
      sequenceEnd <= 1'b1;
      @(posedge clock);
      sequenceEnd <= 1'b0;
      repeat (3) @(posedge clock);
   endtask

   // scoreboard: oldest note against each answer as it is taken
   // quiet in reset, outputs are unknown before the first reset edge
   always @(posedge clock)
   begin
      if (nrst && rvalid && rready)
      begin
         expRead = readQ.pop_front();
         `CHK({rresp, rdata}, expRead)
      end
      if (nrst && bvalid && bready)
      begin
         expResp = respQ.pop_front();
         `CHK(bresp, expResp)
      end
      if (nrst && startSequence !== 4'h0)
      begin
         expTrig = trigQ.pop_front();
         `CHK(startSequence, expTrig)
      end
   end

   initial
   begin
      seed = 51;
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      for (int i = 0; i < 7; i++)
         axiRead(OFS[i], 34'h0);
      axiRead(`OFS_MEM_PART, {22'h0, `MEM_PART_RESET});
      axiRead(`OFS_TRIG_REQ, 34'h0);
      // random words, reserved bits must vanish on read back
      for (int i = 0; i < 7; i++)
      begin
         wv[i] = $random(seed);
         axiWrite(OFS[i], wv[i], 4'hf, 2'b00);
         axiRead(OFS[i], {2'b00, wv[i] & MSK[i]});
      end
      for (int j = 0; j < 4; j++)
         `CHK(seqDesc[SEQ_IDX[j]], {wv[j][26:16], wv[j][10:0]})
      `CHK(commandWritePointer, wv[4][10:0])
      `CHK(upperWatermark, wv[5][26:16])
      `CHK(gpioSync, wv[6][7:0])
      // single byte lane merges into the held value
      axiWrite(`OFS_SEQ0_DESC, 32'hffffffff, 4'h4, 2'b00);
      axiRead(`OFS_SEQ0_DESC, {2'b00, (wv[0] & MSK[0]) | 32'h00ff0000});
      // size codes 1 to 3, data modes 2 and 3, command mode 1
      for (int k = 1; k < 4; k++)
      begin
         d = {20'h0, 3'(2 + k % 2), 3'(k), 3'h1, 3'(k)};
         axiWrite(`OFS_MEM_PART, d, 4'hf, 2'b00);
         axiRead(`OFS_MEM_PART, {2'b00, d});
         `CHK(memPart, d[11:0])
      end
      for (int k = 0; k < 3; k++)
      begin
         w = 11'($random(seed));
         wordsHeld <= w;
         axiRead(`OFS_DQ_COUNT, {7'h0, w, 16'h0});
      end
      // each trigger bit with reserved bits set alongside
      for (int k = 0; k < 4; k++)
      begin
         axiWrite(`OFS_TRIG_REQ, 32'hfff0 | (32'h1 << k), 4'h3, 2'b00);
         @(posedge clock);
         sequenceEnd <= 1'b1;
         @(posedge clock);
         sequenceEnd <= 1'b0;
      end
      axiRead(`OFS_TRIG_REQ, 34'h0);
      // locked, then a wrong password relocks after an unlock
      runSequence(32'h1);
      `CHK(sleepRequest, 1'b0)
      axiWrite(`OFS_SLEEP_LOCK, {12'h0, `SLEEP_PASSWORD}, 4'hf, 2'b00);
      axiWrite(`OFS_SLEEP_LOCK, 32'h000a47e4, 4'hf, 2'b00);
      runSequence(32'h1);
      `CHK(sleepRequest, 1'b0)
      axiRead(`OFS_SLEEP_TRIG, 34'h0);
      axiWrite(`OFS_SLEEP_LOCK, {12'h0, `SLEEP_PASSWORD}, 4'hf, 2'b00);
      axiRead(`OFS_SLEEP_LOCK, {14'h0, `SLEEP_PASSWORD});
      runSequence(32'hffffffff);
      `CHK(sleepRequest, 1'b1)
      axiRead(`OFS_SEQ_STATUS, 34'h4);
      axiRead(`OFS_SLEEP_TRIG, 34'h0);
      axiWrite(`OFS_TRIG_REQ, 32'h2, 4'hf, 2'b00);
      repeat (2) @(posedge clock);
      `CHK(sleepRequest, 1'b0)
      // unmapped place answers with an error and no data
      axiRead(16'h1000, {2'b10, 32'h0});
      axiWrite(16'h1000, 32'h1, 4'hf, 2'b10);
      repeat (5) @(posedge clock);
      `CHK(trigQ.size(), 0)
      conclude();
   end
endmodule // sequencer_fifo_control_regs_test
`default_nettype wire
